/* File: rtl/ppcs_top.sv */
// Peripheral pin select and peripheral clock enable block
`timescale 1ns/100ps

module ppcs_top (
	input  wire logic                             clock,        // Core clk
	input  wire logic                             rst_n,        // Reset
	// Register port
	input  wire logic                             reg_sel,      // Block sel
	input  wire logic [ppcs_pkg::PPCS_ADDR_W-1:0] reg_addr,     // Word off
	input  wire logic                             reg_wr,       // Write
	input  wire logic                             reg_rd,       // Read
	input  wire logic [ppcs_pkg::PPCS_DATA_W-1:0] reg_wdata,    // Wr data
	output logic      [ppcs_pkg::PPCS_DATA_W-1:0] reg_rdata_q,  // Rd data
	output logic                                  reg_rvalid_q, // Rd valid
	// Clock control toward the clock generator
	output logic                                  timer_fast_q, // Timer 3x
	output logic                                  pwm_fast_q,   // PWM 3x
	output logic [ppcs_pkg::PPCS_NUM_PERIPH-1:0]  clk_en_q,     // Gates
	// Peripheral bus write gating
	input  wire logic [ppcs_pkg::PPCS_NUM_PERIPH-1:0] periph_wr_req, // Req
	output logic      [ppcs_pkg::PPCS_NUM_PERIPH-1:0] periph_wr_q,   // Pass
	// Pads
	input  wire logic [ppcs_pkg::PPCS_NUM_PADS-1:0] pad_periph_en, // Own
	input  wire logic [ppcs_pkg::PPCS_NUM_PADS-1:0] pad_in,      // Pad lvl
	output logic      [ppcs_pkg::PPCS_NUM_PADS-1:0] pad_out_q,   // Pad drv
	output logic      [ppcs_pkg::PPCS_NUM_PADS-1:0] pad_oe_q,    // Pad oe
	// Peripheral signals, indexed by the function code
	input  wire logic [ppcs_pkg::PPCS_NUM_FN-1:0]   fn_out,      // Drive
	input  wire logic [ppcs_pkg::PPCS_NUM_FN-1:0]   fn_oe,       // Enable
	output logic      [ppcs_pkg::PPCS_NUM_FN-1:0]   fn_in_q      // Level in
);
	import ppcs_pkg::*;

	localparam int NP = PPCS_NUM_PADS;
	localparam int NF = PPCS_NUM_FN;

	logic [PPCS_DATA_W-1:0]     pin_select_q;
	logic [PPCS_DATA_W-1:0]     clk_enable_q;
	logic                       wr_pin_select;
	logic                       wr_clk_enable;
	logic [PPCS_NUM_PERIPH-1:0] en_req;
	logic [NP-1:0]              pad_s1_q;
	logic [NP-1:0]              pad_s2_q;
	ppcs_fn_type                pad_fn [NP];
	logic [NP-1:0]              pad_out_d;
	logic [NP-1:0]              pad_oe_d;
	logic [NF-1:0]              fn_in_d;

	// Map a pad and the select register to the routed signal
	function automatic ppcs_fn_type route_fn(
		input int           pad,
		input logic [15:0]  sel
	);
		ppcs_fn_type f;
		f = PPCS_FN_PWM_X;
		case (pad)
			0: begin
				f = sel[PPCS_B0_BIT] ? PPCS_FN_SCL : PPCS_FN_SCLK;
			end
			1: begin
				f = sel[PPCS_B1_BIT] ? PPCS_FN_SDA : PPCS_FN_SSEL;
			end
			2: begin
				f = sel[PPCS_B2_BIT] ? PPCS_FN_TPIN2 : PPCS_FN_MISO;
			end
			3: begin
				f = sel[PPCS_B3_BIT] ? PPCS_FN_TPIN3 : PPCS_FN_MOSI;
			end
			4: begin
				f = sel[PPCS_B4_BIT] ? PPCS_FN_CLKOUT : PPCS_FN_TPIN0;
			end
			5: begin
				f = sel[PPCS_B5_BIT] ? PPCS_FN_PWM_FAULT_IN_THREE : PPCS_FN_TPIN1;
			end
			6: begin
				f = sel[PPCS_B6_BIT] ? PPCS_FN_SDA : PPCS_FN_SER_RX;
			end
			7: begin
				f = sel[PPCS_B7_BIT] ? PPCS_FN_SCL : PPCS_FN_SER_TX;
			end
			PPCS_PAD_A4: begin
				// Codes 00 and 01 both give the PWM channel
				case (sel[PPCS_A4_LSB +: 2])
					2'b10:   f = PPCS_FN_PWM_FAULT_IN_ONE;
					2'b11:   f = PPCS_FN_TPIN2;
					default: f = PPCS_FN_PWM_CHANNEL_FOUR_OUT;
				endcase
			end
			PPCS_PAD_A5: begin
				case (sel[PPCS_A5_LSB +: 2])
					2'b10:   f = PPCS_FN_PWM_FAULT_IN_TWO;
					2'b11:   f = PPCS_FN_TPIN3;
					default: f = PPCS_FN_PWM_CHANNEL_FIVE_OUT;
				endcase
			end
			default: begin
				f = PPCS_FN_PWM_X;
			end
		endcase
		return f;
	endfunction

	// Register write decode
	assign wr_pin_select = reg_sel && reg_wr &&
		(reg_addr == PPCS_PIN_SELECT_OFF);
	assign wr_clk_enable = reg_sel && reg_wr &&
		(reg_addr == PPCS_CLK_ENABLE_OFF);

	// Pin select register; masked so reserved bits stay zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_select_q <= PPCS_PIN_SELECT_RST;
		end else if (wr_pin_select) begin
			pin_select_q <= reg_wdata & PPCS_PIN_SELECT_MASK;
		end
	end

	// Clock enable register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			clk_enable_q <= PPCS_CLK_ENABLE_RST;
		end else if (wr_clk_enable) begin
			clk_enable_q <= reg_wdata & PPCS_CLK_ENABLE_MASK;
		end
	end

	// Read port; one cycle latency, unmapped offsets read zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata_q  <= '0;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_sel && reg_rd;
			if (reg_sel && reg_rd) begin
				case (reg_addr)
					PPCS_PIN_SELECT_OFF: reg_rdata_q <= pin_select_q;
					PPCS_CLK_ENABLE_OFF: reg_rdata_q <= clk_enable_q;
					default:             reg_rdata_q <= '0;
				endcase
			end
		end
	end

	// Rate selects toward the clock generator. Software must keep
	// the timer/PWM gated while changing these and only pick 3x
	// with the PLL running; the block does not police that.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer_fast_q <= 1'b0;
			pwm_fast_q   <= 1'b0;
		end else begin
			timer_fast_q <= pin_select_q[PPCS_TIMER_RATE_BIT];
			pwm_fast_q   <= pin_select_q[PPCS_PWM_RATE_BIT];
		end
	end

	// Gather enables in peripheral order
	assign en_req[PPCS_P_PWM]    = clk_enable_q[PPCS_CE_PWM_BIT];
	assign en_req[PPCS_P_SPI]    = clk_enable_q[PPCS_CE_SPI_BIT];
	assign en_req[PPCS_P_SERIAL] = clk_enable_q[PPCS_CE_SERIAL_BIT];
	assign en_req[PPCS_P_TIMER]  = clk_enable_q[PPCS_CE_TIMER_BIT];
	assign en_req[PPCS_P_ADC]    = clk_enable_q[PPCS_CE_ADC_BIT];
	assign en_req[PPCS_P_I2C]    = clk_enable_q[PPCS_CE_I2C_BIT];

	// Edge-aligned enable stage for the clock gates
	ppcs_clk_gate_ctl #(
		.N (PPCS_NUM_PERIPH)
	) u_gate (
		.clock  (clock),
		.rst_n  (rst_n),
		.en_req (en_req),
		.en_q   (clk_en_q)
	);

	// Bus writes pass only to peripherals whose clock runs;
	// uses the register value, so a same-cycle disable does not block
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			periph_wr_q <= '0;
		end else begin
			periph_wr_q <= periph_wr_req & en_req;
		end
	end

	// Two-flop synchroniser on pad levels; first stage feeds only
	// the second
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pad_s1_q <= '0;
			pad_s2_q <= '0;
		end else begin
			pad_s1_q <= pad_in;
			pad_s2_q <= pad_s1_q;
		end
	end

	// Per-pad output routing
	generate
		for (genvar p = 0; p < NP; p++) begin : g_pad
			assign pad_fn[p] = route_fn(p, pin_select_q);
			// GPIO owns the pad unless its peripheral enable is set
			assign pad_oe_d[p]  = pad_periph_en[p] &&
				fn_oe[pad_fn[p]];
			assign pad_out_d[p] = pad_periph_en[p] &&
				fn_out[pad_fn[p]];
		end
	endgenerate

	// Inputs to peripherals: OR of every enabled pad routed there,
	// so a doubly routed input sees either pad
	always_comb begin
		fn_in_d = '0;
		for (int p = 0; p < NP; p++) begin
			if (pad_periph_en[p]) begin
				fn_in_d[pad_fn[p]] = fn_in_d[pad_fn[p]] |
					pad_s2_q[p];
			end
		end
	end

	// Registered pad and peripheral-side outputs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pad_out_q <= '0;
			pad_oe_q  <= '0;
			fn_in_q   <= '0;
		end else begin
			pad_out_q <= pad_out_d;
			pad_oe_q  <= pad_oe_d;
			fn_in_q   <= fn_in_d;
		end
	end

endmodule

/* File: rtl/ppcs_pkg.sv */
// Package: register map, field positions and pad/function codes
package ppcs_pkg;

	// Register word offsets on the peripheral bus
	localparam logic [3:0]  PPCS_PIN_SELECT_OFF = 4'hB;
	localparam logic [3:0]  PPCS_CLK_ENABLE_OFF = 4'hC;
	localparam int          PPCS_ADDR_W         = 4;
	localparam int          PPCS_DATA_W         = 16;

	// Reset values
	localparam logic [15:0] PPCS_PIN_SELECT_RST = 16'h0000;
	localparam logic [15:0] PPCS_CLK_ENABLE_RST = 16'h0000;

	// Writable bit masks; every other bit reads zero
	localparam logic [15:0] PPCS_PIN_SELECT_MASK = 16'hCFFF;
	localparam logic [15:0] PPCS_CLK_ENABLE_MASK = 16'hA055;

	// Pin select field positions
	localparam int PPCS_TIMER_RATE_BIT = 15;
	localparam int PPCS_PWM_RATE_BIT   = 14;
	localparam int PPCS_B7_BIT         = 11;
	localparam int PPCS_B6_BIT         = 10;
	localparam int PPCS_B5_BIT         = 9;
	localparam int PPCS_B4_BIT         = 8;
	localparam int PPCS_B3_BIT         = 7;
	localparam int PPCS_B2_BIT         = 6;
	localparam int PPCS_B1_BIT         = 5;
	localparam int PPCS_B0_BIT         = 4;
	localparam int PPCS_A5_LSB         = 2;
	localparam int PPCS_A4_LSB         = 0;

	// Clock enable field positions
	localparam int PPCS_CE_I2C_BIT    = 15;
	localparam int PPCS_CE_ADC_BIT    = 13;
	localparam int PPCS_CE_TIMER_BIT  = 6;
	localparam int PPCS_CE_SERIAL_BIT = 4;
	localparam int PPCS_CE_SPI_BIT    = 2;
	localparam int PPCS_CE_PWM_BIT    = 0;

	// Gated peripherals, index order of the clock enable outputs
	localparam int PPCS_NUM_PERIPH = 6;
	localparam int PPCS_P_PWM      = 0;
	localparam int PPCS_P_SPI      = 1;
	localparam int PPCS_P_SERIAL   = 2;
	localparam int PPCS_P_TIMER    = 3;
	localparam int PPCS_P_ADC      = 4;
	localparam int PPCS_P_I2C      = 5;

	// Shared pads: port B pins 0..7, then port A pins 4 and 5
	localparam int PPCS_NUM_PADS = 10;
	localparam int PPCS_PAD_A4   = 8;
	localparam int PPCS_PAD_A5   = 9;

	// Peripheral signal codes used by the pad router
	localparam int PPCS_NUM_FN = 19;
	typedef enum logic [4:0] {
		PPCS_FN_SER_TX  = 5'h00,
		PPCS_FN_SER_RX  = 5'h01,
		PPCS_FN_SCL     = 5'h02,
		PPCS_FN_SDA     = 5'h03,
		PPCS_FN_TPIN0   = 5'h04,
		PPCS_FN_TPIN1   = 5'h05,
		PPCS_FN_TPIN2   = 5'h06,
		PPCS_FN_TPIN3   = 5'h07,
		PPCS_FN_PWM_FAULT_IN_ONE  = 5'h08,
		PPCS_FN_PWM_FAULT_IN_TWO  = 5'h09,
		PPCS_FN_PWM_FAULT_IN_THREE  = 5'h0A,
		PPCS_FN_CLKOUT  = 5'h0B,
		PPCS_FN_MOSI    = 5'h0C,
		PPCS_FN_MISO    = 5'h0D,
		PPCS_FN_SSEL    = 5'h0E,
		PPCS_FN_SCLK    = 5'h0F,
		PPCS_FN_PWM_CHANNEL_FOUR_OUT    = 5'h10,
		PPCS_FN_PWM_CHANNEL_FIVE_OUT    = 5'h11,
		PPCS_FN_PWM_X   = 5'h12
	} ppcs_fn_type;

endpackage

/* File: rtl/ppcs_clk_gate_ctl.sv */
// Glitch-free peripheral clock enable stage
`timescale 1ns/100ps
module ppcs_clk_gate_ctl #(
	parameter int N = 6
) (
	input  wire logic         clock,    // Core clock
	input  wire logic         rst_n,    // Sync reset, active low
	input  wire logic [N-1:0] en_req,   // Enables from the register
	output logic      [N-1:0] en_q      // Enables to the clock gates
);

	// Enables change only on the rising edge, so a low-phase
	// latching gate downstream never sees a mid-phase edge and
	// cannot emit a runt pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			en_q <= '0;
		end else begin
			en_q <= en_req;
		end
	end

endmodule

/* File: dv/ppcs_chk.sv */
// Checker for the pin and clock select block
`timescale 1ns/100ps
module ppcs_chk (
	input wire logic        clock,         // Core clock
	input wire logic        rst_n,         // Sync reset
	input wire logic        reg_sel,       // Select
	input wire logic [3:0]  reg_addr,      // Offset
	input wire logic        reg_wr,        // Write
	input wire logic        reg_rd,        // Read
	input wire logic [15:0] reg_wdata,     // Wr data
	input wire logic [15:0] reg_rdata_q,   // Rd data
	input wire logic        reg_rvalid_q,  // Rd valid
	input wire logic        timer_fast_q,  // Timer 3x
	input wire logic        pwm_fast_q,    // PWM 3x
	input wire logic [5:0]  clk_en_q,      // Enables
	input wire logic [5:0]  periph_wr_req, // Wr req
	input wire logic [5:0]  periph_wr_q,   // Wr pass
	input wire logic [9:0]  pad_periph_en, // Owned
	input wire logic [9:0]  pad_out_q,     // Drive
	input wire logic [9:0]  pad_oe_q       // Enable
);
	logic       rd_go;
	logic       ce_go;
	logic       ps_go;
	logic [5:0] ce_pick;
	// Decoded strokes, so $past sees plain signals
	assign rd_go   = reg_sel & reg_rd;
	assign ce_go   = reg_sel & reg_wr & (reg_addr == 4'hC);
	assign ps_go   = reg_sel & reg_wr & (reg_addr == 4'hB);
	assign ce_pick = {reg_wdata[15], reg_wdata[13], reg_wdata[6],
		reg_wdata[4], reg_wdata[2], reg_wdata[0]};
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// Read handshake, one cycle each way
	a_rd_answer: assert property (rd_go |=> reg_rvalid_q)
		else $error("read not answered");
	a_rvalid_cause: assert property (reg_rvalid_q |-> $past(rd_go))
		else $error("read valid without read");
	// Reserved places read as zero
	a_ps_rsvd: assert property (reg_rvalid_q && $past(reg_addr) == 4'hB
		|-> reg_rdata_q[13:12] == 2'b00) else $error("pin rsvd set");
	a_ce_rsvd: assert property (reg_rvalid_q && $past(reg_addr) == 4'hC
		|-> (reg_rdata_q & 16'h5faa) == 16'h0000) else $error("ce rsvd");
	// Rate and enable outputs follow writes two cycles on
	a_rate_follow: assert property (ps_go |-> ##2
		{timer_fast_q, pwm_fast_q} == $past(reg_wdata[15:14], 2))
		else $error("rate select wrong");
	a_ce_follow: assert property (ce_go |-> ##2
		clk_en_q == $past(ce_pick, 2)) else $error("enable wrong");
	a_ce_quiet: assert property ($changed(clk_en_q) |-> $past(ce_go, 2))
		else $error("enable moved without write");
	// Writes pass only to clocked peripherals; only owned pads are driven
	a_wr_gated: assert property (
		periph_wr_q == ($past(periph_wr_req) & clk_en_q))
		else $error("write gate wrong");
	a_pad_owned: assert property (
		((pad_out_q | pad_oe_q) & ~$past(pad_periph_en)) == 10'h000)
		else $error("unowned pad driven");
endmodule

bind ppcs_top ppcs_chk u_ppcs_chk (.clock, .rst_n, .reg_sel, .reg_addr,
	.reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .timer_fast_q,
	.pwm_fast_q, .clk_en_q, .periph_wr_req, .periph_wr_q, .pad_periph_en,
	.pad_out_q, .pad_oe_q);

/* File: dv/ppcs_far_model.sv */
// Far side: peripheral signals and pad wire levels
`timescale 1ns/100ps
module ppcs_far_model (
	input  wire logic        clock,     // Core clock
	input  wire logic        rst_n,     // Sync reset
	input  wire logic        quiet,     // Outputs released
	input  wire logic [9:0]  ext_lvl,   // Board level
	input  wire logic [9:0]  pad_out_q, // Block drive
	input  wire logic [9:0]  pad_oe_q,  // Block enable
	output logic      [18:0] fn_out,    // Peripheral out
	output logic      [18:0] fn_oe,     // Peripheral oe
	output logic      [9:0]  pad_in     // Wire level
);
	logic [31:0] lfsr_q;
	// New values each cycle so a stale route shows
	always_ff @(posedge clock) begin
		if (!rst_n)
			lfsr_q <= 32'h1234_5678;
		else
			lfsr_q <= {lfsr_q[30:0], ^{lfsr_q[31], lfsr_q[21], lfsr_q[1:0]}};
	end
	assign fn_out = lfsr_q[18:0];
	assign fn_oe  = quiet ? 19'h0_0000 : lfsr_q[31:13];
	// Block wins where it drives, else the board level
	assign pad_in = (pad_oe_q & pad_out_q) | (~pad_oe_q & ext_lvl);
endmodule

/* File: dv/ppcs_tb_top.sv */
// Testbench for the pin and clock select block
`timescale 1ns/100ps
module ppcs_tb_top;
	logic        clock = 1'b0, rst_n = 1'b0, quiet = 1'b0;
	logic        reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, d;
	logic        reg_rvalid_q, timer_fast_q, pwm_fast_q;
	logic [5:0]  clk_en_q, periph_wr_q, periph_wr_req = 6'h00;
	logic [9:0]  pad_periph_en = 10'h3ff, ext_lvl = 10'h000;
	logic [9:0]  pad_in, pad_out_q, pad_oe_q;
	logic [18:0] fn_out, fn_oe, fn_in_q, pv, po;
	logic [15:0] expq[$];
	int          miscompares = 0, checks = 0, seed = 32'h1fc2, k;
	// Function codes per pad, select clear and set
	int fa[8] = '{15, 14, 13, 12, 4, 5, 1, 0};
	int fb[8] = '{2, 3, 6, 7, 11, 10, 3, 2};
	int fx[8] = '{16, 16, 8, 6, 17, 17, 9, 7};
	int cb[6] = '{0, 2, 4, 6, 13, 15};

	ppcs_top u_ppcs_top (.clock, .rst_n, .reg_sel, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .timer_fast_q,
		.pwm_fast_q, .clk_en_q, .periph_wr_req, .periph_wr_q,
		.pad_periph_en, .pad_in, .pad_out_q, .pad_oe_q, .fn_out, .fn_oe,
		.fn_in_q);
	ppcs_far_model u_ppcs_far_model (.clock, .rst_n, .quiet, .ext_lvl,
		.pad_out_q, .pad_oe_q, .fn_out, .fn_oe, .pad_in);

	always #2.5 clock = ~clock;

	task automatic chk(input logic [18:0] a, input logic [18:0] e);
		checks++;
		if (a !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask
	// One register access; strobes drop a cycle later
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [15:0] v);
		@(negedge clock);
		reg_sel = 1'b1;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = v;
		@(negedge clock);
		reg_sel = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		expq.push_back(e);
		acc(1'b0, a, 16'h0000);
	endtask
	// Route then compare pad drive with last cycle's peripheral values
	task automatic pchk(input logic [15:0] s, input int p, input int f);
		acc(1'b1, 4'hB, s);
		@(negedge clock);
		pv = fn_out;
		po = fn_oe;
		@(negedge clock);
		chk(pad_out_q[p], pv[f]);
		chk(pad_oe_q[p], po[f]);
	endtask
	task automatic end_sim;
		if (expq.size() != 0)
			miscompares++;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Read results come back in request order
	always @(negedge clock) begin
		if (reg_rvalid_q === 1'b1)
			chk(reg_rdata_q, expq.size() ? expq.pop_front() : 16'hxxxx);
	end

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		end_sim;
	end

	initial begin
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		rd(4'hB, 16'h0000);
		rd(4'hC, 16'h0000);
		// Random data; rates change only with clocks off, PLL assumed on
		for (k = 0; k < 8; k++) begin
			d = 16'($random(seed));
			// Fast PWM only with a fast timer, so a reload link stays legal
			d[15] = d[15] | d[14];
			periph_wr_req = d[5:0];
			acc(1'b1, 4'hC, 16'h0000);
			acc(1'b1, 4'hB, d);
			rd(4'hB, d & 16'hcfff);
			chk({timer_fast_q, pwm_fast_q}, d[15:14]);
			acc(1'b1, 4'hC, ~d);
			rd(4'hC, ~d & 16'ha055);
			acc(1'b1, 4'h3, d);
			rd(4'h3, 16'h0000);
		end
		// One peripheral clocked at a time, all asking to write
		for (k = 0; k < 6; k++) begin
			acc(1'b1, 4'hC, 16'h0001 << cb[k]);
			periph_wr_req = 6'h3f;
			@(negedge clock);
			chk(periph_wr_q, 6'h01 << k);
			chk(clk_en_q, 6'h01 << k);
		end
		for (k = 0; k < 8; k++) begin
			pchk(16'h0000, k, fa[k]);
			pchk(16'h0010 << k, k, fb[k]);
			pchk((k % 4) * 5, 8 + k / 4, fx[k]);
		end
		pchk(16'h0420, 1, 3);
		pchk(16'h0420, 6, 3);
		// Two pads on one input: the levels are ORed
		quiet = 1'b1;
		acc(1'b1, 4'hB, 16'h0810);
		for (k = 0; k < 4; k++) begin
			ext_lvl = {2'b00, k[1], 6'h00, k[0]};
			repeat (4) @(negedge clock);
			chk(fn_in_q[2], k != 0);
		end
		pad_periph_en = 10'h37f;
		ext_lvl = 10'h080;
		repeat (4) @(negedge clock);
		chk(fn_in_q[2], 1'b0);
		// Mid-run reset must bring both registers and rates back to zero
		acc(1'b1, 4'hB, 16'hc001);
		rst_n = 1'b0;
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		rd(4'hB, 16'h0000);
		rd(4'hC, 16'h0000);
		chk({timer_fast_q, pwm_fast_q}, 2'b00);
		chk(clk_en_q, 6'h00);
		repeat (3) @(negedge clock);
		end_sim;
	end
endmodule
